// *** logic/ddr4_pin_iface.sv ***
// device-side pin command, address and data interface with apb mode view
`timescale 1ns/1ps
module ddr4_pin_iface
   import ddr4_pin_pkg::*;
#(
   parameter int ALERT_PAR_CYCLES = ddr4_pin_pkg::ALERT_PAR_CYC,
   parameter int ALERT_CRC_CYCLES = ddr4_pin_pkg::ALERT_CRC_CYC
) (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        resetN,
   input  wire logic        ckT,
   input  wire logic        ckC,
   input  wire logic        cke,
   input  wire logic        csN,
   input  wire logic        actN,
   input  wire logic        rasN,
   input  wire logic        casN,
   input  wire logic        weN,
   input  wire logic [1:0]  bg,
   input  wire logic [1:0]  ba,
   input  wire logic [13:0] addr,
   input  wire logic        odt,
   input  wire logic        par,
   input  wire logic        ten,
   input  wire logic [7:0]  dqIn,
   output      logic [7:0]  dqOut,
   output      logic        dqOe,
   input  wire logic        dqsTIn,
   input  wire logic        dqsCIn,
   output      logic        dqsTOut,
   output      logic        dqsCOut,
   output      logic        dqsOe,
   input  wire logic        dmIn,
   output      logic        dbiOut,
   output      logic        dbiOe,
   input  wire logic        alertIn,
   output      logic        alertOut,
   output      logic        alertOe,
   output      logic        rttNomOn,
   output      logic        tdqsRttOn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output      logic [31:0] prdata,
   output      logic        pready,
   output      logic        pslverr
);
   import ddr4_pin_pkg::*;

   //---------------------------------------------------------------------------
   // helpers
   //---------------------------------------------------------------------------
   function automatic logic more_ones(input logic [7:0] v);
      logic [3:0] n;
      n = 4'h0;
      for (int i = 0; i < 8; i++) begin
         n = n + {3'h0, v[i]};
      end
      return n > 4'h4;
   endfunction

   function automatic logic is_reg(input logic [7:0] a);
      return (a[7:5] == 3'h0) || (a == OFF_CTRL) || (a == OFF_STATUS) ||
             (a == OFF_OPEN) || (a == OFF_LASTROW);
   endfunction

   //---------------------------------------------------------------------------
   // reset and pin synchronisers
   //---------------------------------------------------------------------------
   logic [1:0] rstPipe;
   logic       devReset;

   // asserts at once, releases on the clock to avoid a torn release
   always_ff @(posedge mclk or negedge resetN) begin
      if (!resetN) begin
         rstPipe <= 2'b00;
      end else begin
         rstPipe <= {rstPipe[0], 1'b1};
      end
   end
   assign devReset = rst | ~rstPipe[1]; // R17

   localparam int IN_W = 41;
   logic [IN_W-1:0] pinMeta;
   logic [IN_W-1:0] pinSync;

   always_ff @(posedge mclk) begin
      pinMeta <= {ckT, ckC, cke, csN, actN, rasN, casN, weN, bg, ba, addr, odt, par,
                  ten, dqIn, dqsTIn, dqsCIn, dmIn, alertIn};
      pinSync <= pinMeta;
   end

   logic        sCkT, sCkC, sCke, sCsN, sActN, sRasN, sCasN, sWeN;
   logic [1:0]  sBg, sBa;
   logic [13:0] sAddr;
   logic        sOdt, sPar, sTen, sDqsT, sDqsC, sDm, sAlert;
   logic [7:0]  sDq;
   assign {sCkT, sCkC, sCke, sCsN, sActN, sRasN, sCasN, sWeN, sBg, sBa, sAddr, sOdt, sPar,
           sTen, sDq, sDqsT, sDqsC, sDm, sAlert} = pinSync;

   logic ckPrev;
   logic dqsPrev;
   always_ff @(posedge mclk) begin
      if (devReset) begin
         ckPrev  <= sCkT;
         dqsPrev <= sDqsT;
      end else begin
         ckPrev  <= sCkT;
         dqsPrev <= sDqsT;
      end
   end

   logic ckRise, ckFall, dqsEdge;
   assign ckRise  = sCkT & ~ckPrev & ~sCkC; // R01
   assign ckFall  = ~sCkT & ckPrev;
   // only the true side is edge-detected; the pair is taken as differential
   assign dqsEdge = (sDqsT ^ dqsPrev) & (sDqsT ^ sDqsC); // R19 R09

   //---------------------------------------------------------------------------
   // mode registers and pin function
   //---------------------------------------------------------------------------
   logic [MR_W-1:0] modeReg [8];
   logic [31:0]     ctrl;
   pwr_t            pwr;
   burst_t          burst;
   logic [15:0]     openMask;

   logic tdqsMode, dmOn, wdbiOn, rdbiOn, parEn, crcEn;
   assign tdqsMode = ctrl[0] & modeReg[1][MR1_TDQS]; // R11 R20
   assign dmOn     = ~tdqsMode & modeReg[5][MR5_DM];
   assign wdbiOn   = ~tdqsMode & modeReg[5][MR5_WDBI];
   assign rdbiOn   = ~tdqsMode & modeReg[5][MR5_RDBI];
   assign parEn    = modeReg[5][MR5_PAR_LSB+2:MR5_PAR_LSB] != 3'h0;
   assign crcEn    = modeReg[2][MR2_CRC];

   //---------------------------------------------------------------------------
   // command capture
   //---------------------------------------------------------------------------
   logic [2:0]      cmdBits;
   logic [MR_W-1:0] rowOp;
   logic            cmdSel, parityBad, cmdOk;
   logic            isAct, isMrs, isPre, isWr, isRd;

   assign cmdBits   = {sRasN, sCasN, sWeN};
   assign rowOp     = {sRasN, sCasN, sWeN, sAddr}; // R07 R13
   // commands only when awake; chip select high masks everything
   assign cmdSel    = ckRise & (pwr == PWR_ACTIVE) & sCke & ~sCsN; // R05 R02
   assign parityBad = cmdSel & parEn &
                      (^{sActN, sRasN, sCasN, sWeN, sBg, sBa, sAddr, sPar}); // R21
   assign cmdOk     = cmdSel & ~parityBad;
   assign isAct     = cmdOk & ~sActN; // R07
   assign isMrs     = cmdOk & sActN & (cmdBits == CMD_MRS); // R08
   assign isPre     = cmdOk & sActN & (cmdBits == CMD_PRE);
   assign isWr      = cmdOk & sActN & (cmdBits == CMD_WR) & (burst == BUR_IDLE);
   assign isRd      = cmdOk & sActN & (cmdBits == CMD_RD) & (burst == BUR_IDLE);

   always_ff @(posedge mclk) begin
      if (devReset) begin
         for (int i = 0; i < 8; i++) begin
            modeReg[i] <= '0;
         end
      end else if (isMrs) begin
         modeReg[{sBg[0], sBa}] <= rowOp; // R12 R13
      end
   end

   logic [20:0] lastRow;
   always_ff @(posedge mclk) begin
      if (devReset) begin
         lastRow <= '0;
      end else if (isAct) begin
         lastRow <= {sBg, sBa, rowOp}; // R07 R12
      end
   end

   //---------------------------------------------------------------------------
   // power state
   //---------------------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (devReset) begin
         pwr <= PWR_ACTIVE;
      end else begin
         case (pwr)
            PWR_ACTIVE: begin
               if (ckRise && !sCke) begin // R02
                  if (!sCsN && sActN && cmdBits == CMD_REF) begin
                     pwr <= PWR_SELF_REF;
                  end else if (openMask == 16'h0000) begin
                     pwr <= PWR_PRE_PD;
                  end else begin
                     pwr <= PWR_ACT_PD;
                  end
               end
            end
            // clock buffer is off here, so exit follows the enable level
            PWR_SELF_REF: begin
               if (sCke) begin // R04
                  pwr <= PWR_ACTIVE;
               end
            end
            default: begin
               if (ckRise && sCke) begin // R04
                  pwr <= PWR_ACTIVE;
               end
            end
         endcase
      end
   end

   //---------------------------------------------------------------------------
   // burst engine
   //---------------------------------------------------------------------------
   logic [3:0] beatCnt, beatLen;
   logic [3:0] burstBank;
   logic [2:0] burstCol;
   logic       burstAp;
   logic [7:0] crcAcc;
   logic       burstDone, crcBad, fullBurst, ckEdge;
   logic [7:0] mem [128];
   logic [6:0] memAddr;
   logic [7:0] memRd, wrData;
   logic       memWe;

   assign fullBurst = (modeReg[0][MR0_BL_LSB+1:MR0_BL_LSB] == BL_OTF) ? sAddr[12] :
                      (modeReg[0][MR0_BL_LSB+1:MR0_BL_LSB] != BL_CHOP4); // R16
   assign ckEdge    = (ckRise | ckFall) & (pwr == PWR_ACTIVE);
   assign memAddr   = {burstBank, burstCol + beatCnt[2:0]};
   assign memRd     = mem[memAddr];
   assign wrData    = (wdbiOn && !sDm) ? ~sDq : sDq; // R10
   assign memWe     = (burst == BUR_WRITE) & dqsEdge & (beatCnt < beatLen) &
                      ~(dmOn & ~sDm); // R09
   assign burstDone = (burst != BUR_IDLE) & (beatCnt == beatLen + {3'h0, crcEn}) &
                      (burst == BUR_WRITE ? dqsEdge : ckEdge);
   assign crcBad    = (burst == BUR_WRITE) & dqsEdge & crcEn & (beatCnt == beatLen) &
                      (crcAcc != sDq); // R18

   // storage keeps no row: one byte lane, eight columns per bank
   always_ff @(posedge mclk) begin
      if (memWe) begin
         mem[memAddr] <= wrData;
      end
   end

   always_ff @(posedge mclk) begin
      if (devReset) begin
         burst     <= BUR_IDLE;
         beatCnt   <= 4'h0;
         beatLen   <= BEATS_FULL;
         burstBank <= 4'h0;
         burstCol  <= 3'h0;
         burstAp   <= 1'b0;
         crcAcc    <= 8'h00;
      end else if (isWr || isRd) begin
         burst     <= isWr ? BUR_WRITE : BUR_READ;
         beatCnt   <= 4'h0;
         beatLen   <= fullBurst ? BEATS_FULL : BEATS_CHOP; // R16
         burstBank <= {sBg, sBa}; // R12
         burstCol  <= sAddr[2:0]; // R13
         burstAp   <= sAddr[10]; // R14
         crcAcc    <= 8'h00;
      end else if (burstDone) begin
         burst <= BUR_IDLE;
      end else if (burst == BUR_WRITE && dqsEdge) begin
         beatCnt <= beatCnt + 4'h1;
         if (beatCnt < beatLen) begin
            crcAcc <= crcAcc ^ sDq; // R18
         end
      end else if (burst == BUR_READ && ckEdge) begin
         beatCnt <= beatCnt + 4'h1;
         if (beatCnt < beatLen) begin
            crcAcc <= crcAcc ^ ((rdbiOn && more_ones(memRd)) ? ~memRd : memRd);
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (devReset) begin
         openMask <= 16'h0000;
      end else begin
         if (isAct) begin
            openMask[{sBg, sBa}] <= 1'b1;
         end else if (isPre && sAddr[10]) begin
            openMask <= 16'h0000; // R15
         end else if (isPre) begin
            openMask[{sBg, sBa}] <= 1'b0; // R15
         end else if (burstDone && burstAp) begin
            openMask[burstBank] <= 1'b0; // R14
         end
      end
   end

   //---------------------------------------------------------------------------
   // read drivers
   //---------------------------------------------------------------------------
   logic readDrive;
   always_ff @(posedge mclk) begin
      if (devReset) begin
         dqOut     <= 8'h00;
         dbiOut    <= 1'b1;
         dqsTOut   <= 1'b0;
         readDrive <= 1'b0;
      end else if (burst == BUR_READ && ckEdge) begin
         if (beatCnt < beatLen) begin
            readDrive <= 1'b1;
            dqsTOut   <= ~dqsTOut; // R19
            if (rdbiOn && more_ones(memRd)) begin
               dqOut  <= ~memRd; // R10
               dbiOut <= 1'b0;
            end else begin
               dqOut  <= memRd;
               dbiOut <= 1'b1;
            end
         end else if (crcEn && beatCnt == beatLen) begin
            dqsTOut <= ~dqsTOut;
            dqOut   <= crcAcc; // R18
            dbiOut  <= 1'b1;
         end else begin
            readDrive <= 1'b0;
            dqsTOut   <= 1'b0;
         end
      end else if (burst != BUR_READ) begin
         readDrive <= 1'b0;
         dqsTOut   <= 1'b0;
      end
   end

   // drivers are released whenever the clock enable has put the part to sleep
   assign dqOe    = readDrive & (pwr == PWR_ACTIVE); // R02
   assign dqsOe   = dqOe;
   assign dqsCOut = ~dqsTOut; // R19
   assign dbiOe   = dqOe & rdbiOn; // R11

   //---------------------------------------------------------------------------
   // termination
   //---------------------------------------------------------------------------
   logic odtReg;
   always_ff @(posedge mclk) begin
      if (devReset) begin
         odtReg <= 1'b0;
      end else if (pwr == PWR_SELF_REF) begin
         odtReg <= 1'b0; // R04
      end else if (ckRise) begin
         odtReg <= sOdt; // R06
      end
   end
   assign rttNomOn  = odtReg & (modeReg[1][MR1_RTT_LSB+2:MR1_RTT_LSB] != 3'h0); // R06
   assign tdqsRttOn = rttNomOn & tdqsMode; // R20

   //---------------------------------------------------------------------------
   // alert
   //---------------------------------------------------------------------------
   logic [15:0] alertCnt;
   always_ff @(posedge mclk) begin
      if (devReset) begin
         alertCnt <= 16'h0000;
      end else if (parityBad) begin
         alertCnt <= 16'(ALERT_PAR_CYCLES); // R22
      end else if (crcBad && alertCnt < 16'(ALERT_CRC_CYCLES)) begin
         alertCnt <= 16'(ALERT_CRC_CYCLES); // R22
      end else if (alertCnt != 16'h0000) begin
         alertCnt <= alertCnt - 16'h0001;
      end
   end
   // in connectivity test the pin becomes an input, so never drive it
   assign alertOut = 1'b0;
   assign alertOe  = (alertCnt != 16'h0000) & ~sTen; // R22

   //---------------------------------------------------------------------------
   // apb slave
   //---------------------------------------------------------------------------
   logic parErrFlag, crcErrFlag, wrAcc, w1c;
   assign wrAcc   = psel & penable & pwrite;
   assign w1c     = wrAcc & (paddr == OFF_STATUS);
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~is_reg(paddr);

   always_ff @(posedge mclk) begin
      if (devReset) begin
         ctrl <= CTRL_RESET;
      end else if (wrAcc && paddr == OFF_CTRL) begin
         ctrl <= {31'h0, pwdata[0]};
      end
   end

   // a fresh error in the clearing cycle stays set
   always_ff @(posedge mclk) begin
      if (devReset) begin
         parErrFlag <= 1'b0;
         crcErrFlag <= 1'b0;
      end else begin
         parErrFlag <= parityBad | (parErrFlag & ~(w1c & pwdata[ST_PAR_ERR]));
         crcErrFlag <= crcBad | (crcErrFlag & ~(w1c & pwdata[ST_CRC_ERR]));
      end
   end

   always_ff @(posedge mclk) begin
      if (devReset) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable) begin
         prdata <= 32'h0000_0000;
         if (paddr[7:5] == OFF_MR_BASE[7:5] && paddr[1:0] == 2'h0) begin
            prdata <= {15'h0, modeReg[paddr[4:2]]};
         end else if (paddr == OFF_CTRL) begin
            prdata <= ctrl;
         end else if (paddr == OFF_STATUS) begin
            prdata[ST_PWR_LSB+1:ST_PWR_LSB]     <= pwr;
            prdata[ST_ALERT]                    <= alertOe;
            prdata[ST_TEST]                     <= sTen;
            prdata[ST_PAR_ERR]                  <= parErrFlag;
            prdata[ST_CRC_ERR]                  <= crcErrFlag;
            prdata[ST_ALERT_IN]                 <= sAlert;
            prdata[ST_BURST_LSB+1:ST_BURST_LSB] <= burst;
         end else if (paddr == OFF_OPEN) begin
            prdata <= {16'h0, openMask};
         end else if (paddr == OFF_LASTROW) begin
            prdata <= {11'h0, lastRow};
         end
      end
   end

endmodule

// *** logic/ddr4_pin_pkg.sv ***
// constants and types shared by the pin command interface
//------------------------------------------------------------------------------
// Behaviour
// R01 - capture address and control on clock crossing
// R02 - clock enable gates clocks, buffers, drivers, power-down
// R03 - controller keeps clock enable high during accesses
// R04 - power-down keeps clock, ODT, CKE; self-refresh only CKE
// R05 - chip select high masks commands, selects rank
// R06 - registered ODT enables termination unless disabled
// R07 - activate reuses command pins as row bits
// R08 - activate pin high makes them command pins
// R09 - mask low discards write beat, both strobe edges
// R10 - inversion flag low inverts stored or driven data
// R11 - mode registers pick mask, inversion or termination strobe
// R12 - bank inputs select target or mode register
// R13 - address carries row, column or opcode
// R14 - A10 high auto-precharges after read or write
// R15 - precharge A10 selects one bank or all
// R16 - A12 low chops an on-the-fly burst
// R17 - reset pin low resets asynchronously
// R18 - checksum beat follows each burst when enabled
// R19 - strobe is differential, edge or centre aligned
// R20 - termination strobe copies strobe termination when set
// R21 - even parity check on selected commands
// R22 - alert pulses on checksum, holds on parity, input in test
//------------------------------------------------------------------------------
package ddr4_pin_pkg;

   // apb map
   localparam logic [7:0]  OFF_MR_BASE  = 8'h00;
   localparam logic [7:0]  OFF_CTRL     = 8'h20;
   localparam logic [7:0]  OFF_STATUS   = 8'h24;
   localparam logic [7:0]  OFF_OPEN     = 8'h28;
   localparam logic [7:0]  OFF_LASTROW  = 8'h2c;
   localparam logic [31:0] CTRL_RESET   = 32'h0000_0001;

   // status fields
   localparam int ST_PWR_LSB   = 0;
   localparam int ST_ALERT     = 2;
   localparam int ST_TEST      = 3;
   localparam int ST_PAR_ERR   = 4;
   localparam int ST_CRC_ERR   = 5;
   localparam int ST_ALERT_IN  = 6;
   localparam int ST_BURST_LSB = 8;

   // mode register fields
   localparam int MR_W         = 17;
   localparam int MR0_BL_LSB   = 0;
   localparam int MR1_RTT_LSB  = 8;
   localparam int MR1_TDQS     = 11;
   localparam int MR2_CRC      = 12;
   localparam int MR5_PAR_LSB  = 0;
   localparam int MR5_DM       = 10;
   localparam int MR5_WDBI     = 11;
   localparam int MR5_RDBI     = 12;
   localparam logic [1:0] BL_FIXED8 = 2'h0;
   localparam logic [1:0] BL_OTF    = 2'h1;
   localparam logic [1:0] BL_CHOP4  = 2'h2;
   localparam logic [3:0] BEATS_FULL = 4'h8;
   localparam logic [3:0] BEATS_CHOP = 4'h4;

   // alert timing
   localparam int MCLK_HZ      = 10_000_000;
   localparam int ALERT_CRC_NS = 1_000;
   localparam int ALERT_PAR_NS = 20_000;
   localparam int ALERT_CRC_CYC = (ALERT_CRC_NS * (MCLK_HZ / 1_000_000) + 999) / 1000;
   localparam int ALERT_PAR_CYC = (ALERT_PAR_NS * (MCLK_HZ / 1_000_000) + 999) / 1000;

   typedef enum logic [1:0] {
      PWR_ACTIVE   = 2'b00,
      PWR_PRE_PD   = 2'b01,
      PWR_ACT_PD   = 2'b10,
      PWR_SELF_REF = 2'b11
   } pwr_t;

   typedef enum logic [1:0] {
      BUR_IDLE  = 2'b00,
      BUR_WRITE = 2'b01,
      BUR_READ  = 2'b10
   } burst_t;

   // {ras_n, cas_n, we_n} with the activate pin high
   typedef enum logic [2:0] {
      CMD_MRS = 3'b000,
      CMD_REF = 3'b001,
      CMD_PRE = 3'b010,
      CMD_WR  = 3'b100,
      CMD_RD  = 3'b101,
      CMD_NOP = 3'b111
   } cmd_t;

endpackage

// *** verif/ddr4_host_model.sv ***
// host controller model driving the command pins
`timescale 1ns/1ps
//------------------------------------
// host model
//------------------------------------
module ddr4_host_model (
   input  wire logic mclk,
   output logic        ckT,
   output logic        ckC,
   output logic        cke,
   output logic        csN,
   output logic        actN,
   output logic        rasN,
   output logic        casN,
   output logic        weN,
   output logic [1:0]  bg,
   output logic [1:0]  ba,
   output logic [13:0] addr,
   output logic        odt,
   output logic        par
);
   logic [1:0] phase;
   assign ckC = !ckT;
   initial begin
      phase = 2'h0;
      ckT = 1'b0;
      {cke, odt, par, bg, ba, addr} = {1'b1, 20'h0};
      {csN, actN, rasN, casN, weN} = 5'h1f;
   end
   // free-running pair, eight mclk a period
   always @(posedge mclk) begin
      phase <= phase + 2'h1;
      if (phase == 2'h3) ckT <= !ckT;
   end
   // pins move at ck fall so they are settled round the rise
   task automatic cmd(input logic a, input logic [2:0] c, input logic [1:0] g, k,
                      input logic [13:0] d, input logic s, input logic bad);
      @(negedge ckT);
      csN <= s;
      actN <= a;
      {rasN, casN, weN} <= c;
      {bg, ba, addr} <= {g, k, d};
      par <= ^{a, c, g, k, d} ^ bad;
      @(negedge ckT);
      csN <= 1'b1;
      {actN, rasN, casN, weN} <= 4'hf;
      // released lines flip so a stale value never passes
      {bg, ba, addr} <= ~{g, k, d};
      repeat (4) @(posedge mclk);
   endtask
   // cke only moves between accesses
   task automatic pins(input logic e, input logic o);
      @(negedge ckT);
      cke <= e;
      odt <= o;
      repeat (12) @(posedge mclk);
   endtask
endmodule

// *** verif/ddr4_pin_iface_properties.sv ***
// assertions on the pin interface outputs
`timescale 1ns/1ps
//------------------------------------
// output checker
//------------------------------------
module ddr4_pin_iface_properties #(
   parameter int ALERT_PAR_CYCLES = 200,
   parameter int ALERT_CRC_CYCLES = 10
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic resetN,
   input wire logic cke,
   input wire logic odt,
   input wire logic dqOe,
   input wire logic dqsTOut,
   input wire logic dqsCOut,
   input wire logic dqsOe,
   input wire logic alertOut,
   input wire logic alertOe,
   input wire logic rttNomOn,
   input wire logic tdqsRttOn
);
   logic [15:0] alertRun;
   logic [4:0]  odtLow;
   // length of the current alert pulse
   always_ff @(posedge mclk) begin
      if (rst || !alertOe) alertRun <= '0;
      else alertRun <= alertRun + 16'h1;
   end
   // saturating; odt passes sync and ck capture first
   always_ff @(posedge mclk) begin
      if (rst || odt) odtLow <= '0;
      else if (odtLow != 5'h1f) odtLow <= odtLow + 5'h1;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   chk_alert_level: assert property (alertOe |-> !alertOut)
      else $error("alert pin driven high");
   chk_alert_length: assert property ($fell(alertOe) |->
      alertRun == ALERT_PAR_CYCLES || alertRun == ALERT_CRC_CYCLES)
      else $error("alert pulse length wrong");
   chk_pin_reset: assert property (!resetN |=> !dqOe && !alertOe && !rttNomOn)
      else $error("outputs active in pin reset");
   chk_pd_drivers: assert property (!cke [*8] |-> !dqOe && !dqsOe)
      else $error("drivers on with clock enable low");
   chk_tdqs_term: assert property (tdqsRttOn |-> rttNomOn)
      else $error("strobe copy termination alone");
   chk_strobe_pair: assert property (dqsOe |-> dqsCOut == !dqsTOut)
      else $error("strobe pair not complementary");
   chk_strobe_data: assert property ($rose(dqOe) |-> dqsOe && $changed(dqsTOut))
      else $error("strobe not aligned to first beat");
   chk_rtt_odt: assert property (odtLow == 5'h1f |-> !rttNomOn)
      else $error("termination on without odt");
   cover property ($rose(alertOe));
   cover property ($fell(dqOe));
   cover property (tdqsRttOn);
endmodule

// *** verif/tb_ddr4_pin_iface.sv ***
// self-checking bench for the pin interface
`timescale 1ns/1ps
//------------------------------------
// bench
//------------------------------------
module tb_ddr4_pin_iface;
   import ddr4_pin_pkg::*;
   logic        mclk, rst, resetN, psel, penable, pwrite, e, ten;
   logic [7:0]  paddr, dqOut;
   logic [31:0] pwdata, prdata, r;
   logic        ckT, ckC, cke, csN, actN, rasN, casN, weN, odt, par;
   logic [1:0]  bg, ba;
   logic [13:0] addr;
   logic        pready, pslverr, dqOe, dqsTOut, alertOe, rttNomOn, tdqsRttOn, dbiOut, dbiOe;
   int          failures = 0, comparisons = 0, cyc = 0;
   wire logic   alertIn = !alertOe; // board pull-up on the open-drain alert
   always #50 mclk = !mclk;
   ddr4_host_model i_host (.mclk, .ckT, .ckC, .cke, .csN, .actN, .rasN, .casN, .weN,
      .bg, .ba, .addr, .odt, .par);
   ddr4_pin_iface i_dut (
      .mclk, .rst, .resetN, .ckT, .ckC, .cke, .csN, .actN, .rasN, .casN, .weN, .bg, .ba,
      .addr, .odt, .par, .ten, .dqIn(8'h00), .dqOut, .dqOe, .dqsTIn(1'b0),
      .dqsCIn(1'b1), .dqsTOut, .dqsCOut(), .dqsOe(), .dmIn(1'b1), .dbiOut, .dbiOe,
      .alertIn, .alertOut(), .alertOe, .rttNomOn, .tdqsRttOn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr);
   task automatic check(input logic [31:0] s, input logic [31:0] x);
      comparisons++;
      if (s !== x) begin
         failures++;
         $display("MISMATCH at %0t seen %h expected %h", $time, s, x);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      {pwrite, paddr, pwdata} <= {w, a, d};
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
      @(posedge mclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      check(r, x);
   endtask
   // counts strobe toggles while the device drives data
   task automatic burst(input logic [31:0] n);
      int c;
      logic p;
      c = 0;
      p = dqsTOut;
      repeat (64) begin
         @(posedge mclk);
         if (dqOe === 1'b1 && dqsTOut !== p) c++;
         p = dqsTOut;
      end
      check(c, n);
   endtask
   task automatic conclude();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 6000) begin
         failures++;
         conclude();
      end
   end
   initial begin
      {mclk, rst, resetN, psel, penable, pwrite, ten, paddr, pwdata} = {7'b0110000, 40'h0};
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      rd(OFF_CTRL, CTRL_RESET);
      check({22'h0, dqOut, dbiOut, dbiOe}, 32'h2);
      apb(1'b0, 8'h30, 32'h0);
      check({r[30:0], e}, 32'h1);
      rd(OFF_STATUS, 32'h40);
      $display("end of reset test");
      i_host.cmd(1'b1, CMD_MRS, 2'h0, 2'h0, 14'h0001, 1'b0, 1'b0);
      i_host.cmd(1'b1, CMD_MRS, 2'h0, 2'h1, 14'h0900, 1'b0, 1'b0);
      rd(OFF_MR_BASE + 8'h04, 32'h900);
      rd(OFF_MR_BASE, 32'h1);
      i_host.cmd(1'b0, 3'h5, 2'h2, 2'h3, 14'h1234, 1'b0, 1'b0);
      i_host.cmd(1'b0, 3'h5, 2'h0, 2'h0, 14'h0000, 1'b1, 1'b0);
      rd(OFF_LASTROW, 32'h175234);
      rd(OFF_OPEN, 32'h800);
      fork
         i_host.cmd(1'b1, CMD_RD, 2'h2, 2'h3, 14'h1000, 1'b0, 1'b0);
         burst(32'h8);
      join
      fork
         i_host.cmd(1'b1, CMD_RD, 2'h2, 2'h3, 14'h0400, 1'b0, 1'b0);
         burst(32'h4);
      join
      rd(OFF_OPEN, 32'h0);
      $display("end of activate and read test");
      i_host.cmd(1'b0, 3'h0, 2'h0, 2'h1, 14'h0000, 1'b0, 1'b0);
      i_host.cmd(1'b0, 3'h0, 2'h1, 2'h1, 14'h0000, 1'b0, 1'b0);
      i_host.cmd(1'b1, CMD_PRE, 2'h0, 2'h1, 14'h0000, 1'b0, 1'b0);
      rd(OFF_OPEN, 32'h20);
      i_host.cmd(1'b1, CMD_PRE, 2'h3, 2'h3, 14'h0400, 1'b0, 1'b0);
      rd(OFF_OPEN, 32'h0);
      $display("end of precharge test");
      i_host.pins(1'b0, 1'b0);
      rd(OFF_STATUS, 32'h41);
      i_host.cmd(1'b0, 3'h0, 2'h0, 2'h1, 14'h0000, 1'b0, 1'b0);
      rd(OFF_OPEN, 32'h0);
      i_host.pins(1'b1, 1'b0);
      rd(OFF_STATUS, 32'h40);
      $display("end of power-down test");
      i_host.cmd(1'b1, CMD_MRS, 2'h1, 2'h1, 14'h0001, 1'b0, 1'b0);
      i_host.cmd(1'b0, 3'h0, 2'h0, 2'h2, 14'h0000, 1'b0, 1'b1);
      rd(OFF_STATUS, 32'h14);
      check({31'h0, alertOe}, 32'h1);
      repeat (200) @(posedge mclk);
      apb(1'b1, OFF_STATUS, 32'h10);
      rd(OFF_STATUS, 32'h40);
      i_host.cmd(1'b0, 3'h0, 2'h0, 2'h2, 14'h0000, 1'b0, 1'b0);
      rd(OFF_OPEN, 32'h4);
      ten <= 1'b1;
      repeat (4) @(posedge mclk);
      rd(OFF_STATUS, 32'h48);
      ten <= 1'b0;
      $display("end of parity test");
      i_host.pins(1'b1, 1'b1);
      check({30'h0, rttNomOn, tdqsRttOn}, 32'h3);
      i_host.pins(1'b1, 1'b0);
      check({30'h0, rttNomOn, tdqsRttOn}, 32'h0);
      $display("end of termination test");
      resetN <= 1'b0;
      repeat (2) @(posedge mclk);
      resetN <= 1'b1;
      repeat (4) @(posedge mclk);
      rd(OFF_MR_BASE + 8'h04, 32'h0);
      rd(OFF_OPEN, 32'h0);
      $display("end of pin reset test");
      conclude();
   end
endmodule
bind ddr4_pin_iface ddr4_pin_iface_properties #(
   .ALERT_PAR_CYCLES(ALERT_PAR_CYCLES), .ALERT_CRC_CYCLES(ALERT_CRC_CYCLES)) i_chk (
   .mclk, .rst, .resetN, .cke, .odt, .dqOe, .dqsTOut, .dqsCOut, .dqsOe, .alertOut,
   .alertOe, .rttNomOn, .tdqsRttOn);
